// [hdl/mpc_defs.vh]
// Register offsets, field positions and reset values of the pin controller.
`ifndef MPC_DEFS_VH
`define MPC_DEFS_VH

`define MPC_ADDR_W        6
`define MPC_OFS_SER_DATA  6'h00
`define MPC_OFS_SER_DIR   6'h04
`define MPC_OFS_SER_ATTR  6'h08
`define MPC_OFS_COL_DATA  6'h0C
`define MPC_OFS_COL_DIR   6'h10
`define MPC_OFS_COL_ATTR  6'h14
`define MPC_OFS_SNS_DATA  6'h18
`define MPC_OFS_SNS_DIR   6'h1C
`define MPC_OFS_SNS_ATTR  6'h20
`define MPC_OFS_KEY_DATA  6'h24
`define MPC_OFS_KEY_DIR   6'h28
`define MPC_OFS_KEY_ATTR  6'h2C
`define MPC_OFS_CTRL      6'h30
`define MPC_OFS_PIN_IN    6'h34
`define MPC_OFS_STATUS    6'h38

`define MPC_CTRL_SPI_EN   0
`define MPC_CTRL_RFC_EN   1
`define MPC_CTRL_BUZ_B0   2
`define MPC_CTRL_BUZ_B1   3
`define MPC_CTRL_WAKE_EN  4
`define MPC_CTRL_STOP     5
`define MPC_CTRL_W        5

`define MPC_PIN_SER_LSB   0
`define MPC_PIN_COL_LSB   4
`define MPC_PIN_SNS_LSB   8
`define MPC_PIN_KEY_LSB   14

`define MPC_STAT_STOP     0
`define MPC_STAT_WOKE     1

`define MPC_RST_PORT      1'h0
`define MPC_RST_CTRL      5'h00
`define MPC_RST_WORD      32'h0000_0000

`endif

// [hdl/mpc_pad_cell.v]
// Per-pin pad decode for one port, registered, with a freeze input.
`timescale 1ns/1ps
module mpc_pad_cell #(
	parameter W = 4
) (
	// Clock and reset.
	input  wire         clk,
	input  wire         rst_n,
	// Freeze of all pad outputs.
	input  wire         hold,
	// Pin control bits.
	input  wire [W-1:0] data,
	input  wire [W-1:0] dir,
	input  wire [W-1:0] attr,
	// Special function override.
	input  wire [W-1:0] spec_sel,
	input  wire [W-1:0] spec_o,
	input  wire [W-1:0] spec_oe,
	// Pad drive.
	output reg  [W-1:0] pad_o,
	output reg  [W-1:0] pad_oe,
	output reg  [W-1:0] pad_pl
);
	reg [W-1:0] o_next;
	reg [W-1:0] oe_next;
	reg [W-1:0] pl_next;
	integer     i;

	always @* begin
		o_next  = pad_o;
		oe_next = pad_oe;
		pl_next = pad_pl;
		if (!hold) begin
			for (i = 0; i < W; i = i + 1) begin
				o_next[i]  = 1'b0;
				oe_next[i] = 1'b0;
				pl_next[i] = 1'b0;
				if (spec_sel[i]) begin
					o_next[i]  = spec_o[i];
					oe_next[i] = spec_oe[i];
				end else begin
					case ({attr[i], dir[i], data[i]})
					3'b000: pl_next[i] = 1'b1;
					3'b001: pl_next[i] = 1'b0;
					3'b010: oe_next[i] = 1'b1;
					3'b011: begin
						oe_next[i] = 1'b1;
						o_next[i]  = 1'b1;
					end
					// Code 110 floats; other codes float too.
					default: oe_next[i] = 1'b0;
					endcase
				end
			end
		end
	end

	// Reset state is code 000, an input with pull-low.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pad_o  <= {W{1'b0}};
			pad_oe <= {W{1'b0}};
			pad_pl <= {W{1'b1}};
		end else begin
			pad_o  <= o_next;
			pad_oe <= oe_next;
			pad_pl <= pl_next;
		end
	end
endmodule

// [hdl/mpc_pin_ctrl.v]
// Four-port pin controller with an Avalon-MM register slave.
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`include "mpc_defs.vh"

// Overview of operation
// - After reset every pin of all four ports is a general-purpose input.
// - Each pin has its own data, direction and attribute control bit.
// - Codes 000 pull-low in, 001 pure in, 010 low, 011 high, 110 special.
// - Ports are 4 serial, 4 column, 6 sensor/buzzer and 8 key pins wide.
// - Sensor pins 5 to 3 may be columns 57 to 59, pins 1 and 0 buzzers.
// - The four column-shared pins can be column lines 53 to 56.
// - Serial pins 0 to 3 carry select, clock, data in, data out when on.
// - While serial is on, writes to its four pins' control bits do nothing.
// - Sensing: sensor pins 5 to 3 pass drive out, pin 2 follows its own pin code.
// - Sensor pin 2 is the source of the pin interrupt.
// - With wake enabled, key port activity ends stop-clock mode.
// - In stop-clock mode and across wake-up every pin keeps its state.
// - Buzzer bits both 1 toggle pins 1 and 0 on overflow; both 0 give I/O.
module mpc_pin_ctrl #(
	parameter SER_W = 4,
	parameter COL_W = 4,
	parameter SNS_W = 6,
	parameter KEY_W = 8
) (
	// Clock and reset.
	input  wire              CLK,
	input  wire              RESETN,
	// Avalon-MM slave.
	input  wire [5:0]        AVS_ADDRESS,
	input  wire              AVS_READ,
	input  wire              AVS_WRITE,
	input  wire [31:0]       AVS_WRITEDATA,
	input  wire [3:0]        AVS_BYTEENABLE,
	output reg  [31:0]       AVS_READDATA,
	output reg               AVS_WAITREQUEST,
	// Serial-shared port pads.
	input  wire [SER_W-1:0]  SER_PAD_I,
	output wire [SER_W-1:0]  SER_PAD_O,
	output wire [SER_W-1:0]  SER_PAD_OE,
	output wire [SER_W-1:0]  SER_PAD_PL,
	// Column-shared port pads.
	input  wire [COL_W-1:0]  COL_PAD_I,
	output wire [COL_W-1:0]  COL_PAD_O,
	output wire [COL_W-1:0]  COL_PAD_OE,
	output wire [COL_W-1:0]  COL_PAD_PL,
	// Sensor/buzzer port pads.
	input  wire [SNS_W-1:0]  SNS_PAD_I,
	output wire [SNS_W-1:0]  SNS_PAD_O,
	output wire [SNS_W-1:0]  SNS_PAD_OE,
	output wire [SNS_W-1:0]  SNS_PAD_PL,
	// Key wake port pads.
	input  wire [KEY_W-1:0]  KEY_PAD_I,
	output wire [KEY_W-1:0]  KEY_PAD_O,
	output wire [KEY_W-1:0]  KEY_PAD_OE,
	output wire [KEY_W-1:0]  KEY_PAD_PL,
	// Serial controller side.
	input  wire              SPI_CS_N,
	input  wire              SPI_SCK,
	input  wire              SPI_MOSI,
	output reg               SPI_MISO,
	// Display, sensing unit and buzzer counter side.
	input  wire [6:0]        LCD_COLUMN_DRIVE,
	input  wire [2:0]        RFC_DRIVE,
	output reg               RFC_SENSE,
	input  wire              BUZZ_OVF,
	// Events and power state.
	output reg               PIN_IRQ,
	output reg               WAKE,
	output reg               STOP_ACTIVE
);
	// Pin control registers, one port per group.
	reg [SER_W-1:0] ser_data_reg;
	reg [SER_W-1:0] ser_dir_reg;
	reg [SER_W-1:0] ser_attr_reg;
	reg [COL_W-1:0] col_data_reg;
	reg [COL_W-1:0] col_dir_reg;
	reg [COL_W-1:0] col_attr_reg;
	reg [SNS_W-1:0] sns_data_reg;
	reg [SNS_W-1:0] sns_dir_reg;
	reg [SNS_W-1:0] sns_attr_reg;
	reg [KEY_W-1:0] key_data_reg;
	reg [KEY_W-1:0] key_dir_reg;
	reg [KEY_W-1:0] key_attr_reg;
	reg [4:0]       ctrl_reg;
	reg             woke_reg;
	reg [KEY_W-1:0] key_ref_reg;
	reg             buzz_reg;
	reg             sns2_last_reg;

	// Two-flop synchronisers for every pad input.
	reg [SER_W-1:0] ser_s1_reg;
	reg [SER_W-1:0] ser_s2_reg;
	reg [COL_W-1:0] col_s1_reg;
	reg [COL_W-1:0] col_s2_reg;
	reg [SNS_W-1:0] sns_s1_reg;
	reg [SNS_W-1:0] sns_s2_reg;
	reg [KEY_W-1:0] key_s1_reg;
	reg [KEY_W-1:0] key_s2_reg;

	reg [31:0]      rdata_next;
	wire            req;
	wire            ack;
	wire            wr;
	wire            spi_en;
	wire            rfc_en;
	wire            buzz_on;
	wire            key_act;
	wire [31:0]     pin_in;

	// Pin code 110 is the special-function setting.
	function [7:0] fn_special;
		input [7:0] attr;
		input [7:0] dir;
		input [7:0] data;
		begin
			fn_special = attr & dir & ~data;
		end
	endfunction

	assign req     = AVS_READ | AVS_WRITE;
	assign ack     = req & ~AVS_WAITREQUEST;
	assign wr      = ack & AVS_WRITE & AVS_BYTEENABLE[0];
	assign spi_en  = ctrl_reg[`MPC_CTRL_SPI_EN];
	assign rfc_en  = ctrl_reg[`MPC_CTRL_RFC_EN];
	assign buzz_on = ctrl_reg[`MPC_CTRL_BUZ_B1] & ctrl_reg[`MPC_CTRL_BUZ_B0];
	assign key_act = |(key_s2_reg ^ key_ref_reg);
	assign pin_in  = {10'h000, key_s2_reg, sns_s2_reg, col_s2_reg,
		ser_s2_reg};

	// Serial pins are owned by the serial controller while on.
	wire [SER_W-1:0] ser_sel = {SER_W{spi_en}};
	wire [SER_W-1:0] ser_so  = {SPI_MOSI, 1'b0, SPI_SCK, SPI_CS_N};
	wire [SER_W-1:0] ser_soe = 4'b1011;

	// Column port drives columns 53 to 56 when set to 110.
	wire [7:0]       col_spec = fn_special({4'h0, col_attr_reg},
		{4'h0, col_dir_reg}, {4'h0, col_data_reg});
	wire [COL_W-1:0] col_sel = col_spec[COL_W-1:0];

	// Sensor port: upper pins are columns 57 to 59 or sensor drive,
	// pin 2 follows its own pin code and feeds the sensor input, pins 1 and 0 buzz.
	wire [7:0]       sns_spec = fn_special({2'h0, sns_attr_reg},
		{2'h0, sns_dir_reg}, {2'h0, sns_data_reg});
	wire [SNS_W-1:0] sns_sel = {sns_spec[5:3], 1'b0, {2{buzz_on}}};
	wire [2:0]       sns_hi  = rfc_en ? RFC_DRIVE : LCD_COLUMN_DRIVE[6:4];
	wire [SNS_W-1:0] sns_so  = {sns_hi, 1'b0, ~buzz_reg, buzz_reg};
	wire [SNS_W-1:0] sns_soe = 6'h3B;

	mpc_pad_cell #(.W(SER_W)) u_ser (
		.clk      (CLK),
		.rst_n    (RESETN),
		.hold     (STOP_ACTIVE),
		.data     (ser_data_reg),
		.dir      (ser_dir_reg),
		.attr     (ser_attr_reg),
		.spec_sel (ser_sel),
		.spec_o   (ser_so),
		.spec_oe  (ser_soe),
		.pad_o    (SER_PAD_O),
		.pad_oe   (SER_PAD_OE),
		.pad_pl   (SER_PAD_PL)
	);

	mpc_pad_cell #(.W(COL_W)) u_col (
		.clk      (CLK),
		.rst_n    (RESETN),
		.hold     (STOP_ACTIVE),
		.data     (col_data_reg),
		.dir      (col_dir_reg),
		.attr     (col_attr_reg),
		.spec_sel (col_sel),
		.spec_o   (LCD_COLUMN_DRIVE[3:0]),
		.spec_oe  ({COL_W{1'b1}}),
		.pad_o    (COL_PAD_O),
		.pad_oe   (COL_PAD_OE),
		.pad_pl   (COL_PAD_PL)
	);

	mpc_pad_cell #(.W(SNS_W)) u_sns (
		.clk      (CLK),
		.rst_n    (RESETN),
		.hold     (STOP_ACTIVE),
		.data     (sns_data_reg),
		.dir      (sns_dir_reg),
		.attr     (sns_attr_reg),
		.spec_sel (sns_sel),
		.spec_o   (sns_so),
		.spec_oe  (sns_soe),
		.pad_o    (SNS_PAD_O),
		.pad_oe   (SNS_PAD_OE),
		.pad_pl   (SNS_PAD_PL)
	);

	mpc_pad_cell #(.W(KEY_W)) u_key (
		.clk      (CLK),
		.rst_n    (RESETN),
		.hold     (STOP_ACTIVE),
		.data     (key_data_reg),
		.dir      (key_dir_reg),
		.attr     (key_attr_reg),
		.spec_sel ({KEY_W{1'b0}}),
		.spec_o   ({KEY_W{1'b0}}),
		.spec_oe  ({KEY_W{1'b0}}),
		.pad_o    (KEY_PAD_O),
		.pad_oe   (KEY_PAD_OE),
		.pad_pl   (KEY_PAD_PL)
	);

	// Read data is formed one cycle early so it stands at the ack edge.
	always @* begin
		rdata_next = `MPC_RST_WORD;
		case (AVS_ADDRESS)
		`MPC_OFS_SER_DATA: rdata_next[SER_W-1:0] = ser_data_reg;
		`MPC_OFS_SER_DIR:  rdata_next[SER_W-1:0] = ser_dir_reg;
		`MPC_OFS_SER_ATTR: rdata_next[SER_W-1:0] = ser_attr_reg;
		`MPC_OFS_COL_DATA: rdata_next[COL_W-1:0] = col_data_reg;
		`MPC_OFS_COL_DIR:  rdata_next[COL_W-1:0] = col_dir_reg;
		`MPC_OFS_COL_ATTR: rdata_next[COL_W-1:0] = col_attr_reg;
		`MPC_OFS_SNS_DATA: rdata_next[SNS_W-1:0] = sns_data_reg;
		`MPC_OFS_SNS_DIR:  rdata_next[SNS_W-1:0] = sns_dir_reg;
		`MPC_OFS_SNS_ATTR: rdata_next[SNS_W-1:0] = sns_attr_reg;
		`MPC_OFS_KEY_DATA: rdata_next[KEY_W-1:0] = key_data_reg;
		`MPC_OFS_KEY_DIR:  rdata_next[KEY_W-1:0] = key_dir_reg;
		`MPC_OFS_KEY_ATTR: rdata_next[KEY_W-1:0] = key_attr_reg;
		`MPC_OFS_CTRL:     rdata_next[4:0]       = ctrl_reg;
		`MPC_OFS_PIN_IN:   rdata_next            = pin_in;
		`MPC_OFS_STATUS: begin
			rdata_next[`MPC_STAT_STOP] = STOP_ACTIVE;
			rdata_next[`MPC_STAT_WOKE] = woke_reg;
		end
		default: rdata_next = `MPC_RST_WORD;
		endcase
	end

	// Bus handshake: one wait cycle, then a one-cycle acknowledge.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			AVS_WAITREQUEST <= 1'b1;
			AVS_READDATA    <= `MPC_RST_WORD;
		end else begin
			AVS_WAITREQUEST <= ~(req & AVS_WAITREQUEST);
			if (req & AVS_WAITREQUEST)
				AVS_READDATA <= rdata_next;
		end
	end

	// Control registers; reset value puts every pin in input mode.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			{ser_data_reg, ser_dir_reg} <= {2*SER_W{`MPC_RST_PORT}};
			ser_attr_reg <= {SER_W{`MPC_RST_PORT}};
			{col_data_reg, col_dir_reg} <= {2*COL_W{`MPC_RST_PORT}};
			col_attr_reg <= {COL_W{`MPC_RST_PORT}};
			{sns_data_reg, sns_dir_reg} <= {2*SNS_W{`MPC_RST_PORT}};
			sns_attr_reg <= {SNS_W{`MPC_RST_PORT}};
			{key_data_reg, key_dir_reg} <= {2*KEY_W{`MPC_RST_PORT}};
			key_attr_reg <= {KEY_W{`MPC_RST_PORT}};
			ctrl_reg     <= `MPC_RST_CTRL;
		end else if (wr) begin
			case (AVS_ADDRESS)
			// Serial pin bits are locked while serial is on.
			`MPC_OFS_SER_DATA: if (!spi_en)
				ser_data_reg <= AVS_WRITEDATA[SER_W-1:0];
			`MPC_OFS_SER_DIR: if (!spi_en)
				ser_dir_reg <= AVS_WRITEDATA[SER_W-1:0];
			`MPC_OFS_SER_ATTR: if (!spi_en)
				ser_attr_reg <= AVS_WRITEDATA[SER_W-1:0];
			`MPC_OFS_COL_DATA: col_data_reg <= AVS_WRITEDATA[COL_W-1:0];
			`MPC_OFS_COL_DIR:  col_dir_reg  <= AVS_WRITEDATA[COL_W-1:0];
			`MPC_OFS_COL_ATTR: col_attr_reg <= AVS_WRITEDATA[COL_W-1:0];
			`MPC_OFS_SNS_DATA: sns_data_reg <= AVS_WRITEDATA[SNS_W-1:0];
			`MPC_OFS_SNS_DIR:  sns_dir_reg  <= AVS_WRITEDATA[SNS_W-1:0];
			`MPC_OFS_SNS_ATTR: sns_attr_reg <= AVS_WRITEDATA[SNS_W-1:0];
			`MPC_OFS_KEY_DATA: key_data_reg <= AVS_WRITEDATA[KEY_W-1:0];
			`MPC_OFS_KEY_DIR:  key_dir_reg  <= AVS_WRITEDATA[KEY_W-1:0];
			`MPC_OFS_KEY_ATTR: key_attr_reg <= AVS_WRITEDATA[KEY_W-1:0];
			`MPC_OFS_CTRL:     ctrl_reg     <= AVS_WRITEDATA[4:0];
			default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// Pad input synchronisers.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			{ser_s2_reg, ser_s1_reg} <= {2*SER_W{1'b0}};
			{col_s2_reg, col_s1_reg} <= {2*COL_W{1'b0}};
			{sns_s2_reg, sns_s1_reg} <= {2*SNS_W{1'b0}};
			{key_s2_reg, key_s1_reg} <= {2*KEY_W{1'b0}};
		end else begin
			{ser_s2_reg, ser_s1_reg} <= {ser_s1_reg, SER_PAD_I};
			{col_s2_reg, col_s1_reg} <= {col_s1_reg, COL_PAD_I};
			{sns_s2_reg, sns_s1_reg} <= {sns_s1_reg, SNS_PAD_I};
			{key_s2_reg, key_s1_reg} <= {key_s1_reg, KEY_PAD_I};
		end
	end

	// Events, buzzer, stop-clock and wake-up.
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			{SPI_MISO, RFC_SENSE, PIN_IRQ, WAKE, STOP_ACTIVE} <= 5'h00;
			{woke_reg, buzz_reg, sns2_last_reg} <= 3'h0;
			key_ref_reg   <= {KEY_W{1'b0}};
		end else begin
			SPI_MISO      <= ser_s2_reg[2];
			RFC_SENSE     <= sns_s2_reg[2];
			sns2_last_reg <= sns_s2_reg[2];
			// Rising edge on sensor pin 2 raises the pin interrupt.
			PIN_IRQ <= sns_s2_reg[2] & ~sns2_last_reg;
			if (!buzz_on)
				buzz_reg <= 1'b0;
			else if (BUZZ_OVF)
				buzz_reg <= ~buzz_reg;
			WAKE <= 1'b0;
			// Pad cells are frozen while stopped; nothing is reloaded on
			// wake, so pins leave stop exactly as they entered it.
			if (!STOP_ACTIVE) begin
				if (wr && AVS_ADDRESS == `MPC_OFS_CTRL &&
					AVS_WRITEDATA[`MPC_CTRL_STOP]) begin
					STOP_ACTIVE <= 1'b1;
					key_ref_reg <= key_s2_reg;
				end
			end else if (ctrl_reg[`MPC_CTRL_WAKE_EN] && key_act) begin
				STOP_ACTIVE <= 1'b0;
				WAKE        <= 1'b1;
			end
			// A new wake beats a software clear in the same cycle.
			if (STOP_ACTIVE && ctrl_reg[`MPC_CTRL_WAKE_EN] && key_act)
				woke_reg <= 1'b1;
			else if (wr && AVS_ADDRESS == `MPC_OFS_STATUS &&
				AVS_WRITEDATA[`MPC_STAT_WOKE])
				woke_reg <= 1'b0;
		end
	end
endmodule

// [bench/mpc_far_model.sv]
// Keys, sensors, glass and serial device seen at the controller's pads.
`timescale 1ns/1ps
module mpc_far_model (
	// Clock.
	input  wire        clk,
	// Pad drive from the controller.
	input  wire [21:0] pad_o,
	input  wire [21:0] pad_oe,
	input  wire [21:0] pad_pl,
	// Levels the outside world puts on the pins, and where it drives.
	input  wire [21:0] pin_interrupt,
	input  wire [21:0] ext_en,
	// Level read back by the controller.
	output wire [21:0] pad_i
);
	reg [21:0] last_reg;

	// An undriven pin without pull shows the inverse of its last level.
	// That way a missing pull cannot hide behind a lucky zero.
	always @(posedge clk) begin
		last_reg <= pad_i;
	end
	assign pad_i = (pad_oe & pad_o) | (~pad_oe & ext_en & pin_interrupt) |
		(~pad_oe & ~ext_en & ~pad_pl & ~last_reg);
endmodule

// [bench/mpc_pin_ctrl_sva.sv]
// Port-level assertions for the pin controller.
`timescale 1ns/1ps
module mpc_pin_ctrl_sva #(
	parameter COL_W = 4,
	parameter SNS_W = 6,
	parameter KEY_W = 8
) (
	// Clock and reset.
	input wire             CLK,
	input wire             RESETN,
	// Register bus.
	input wire             AVS_READ,
	input wire             AVS_WRITE,
	input wire [31:0]      AVS_READDATA,
	input wire             AVS_WAITREQUEST,
	// Pads.
	input wire [COL_W-1:0] COL_PAD_O,
	input wire [SNS_W-1:0] SNS_PAD_I,
	input wire [KEY_W-1:0] KEY_PAD_O,
	input wire [KEY_W-1:0] KEY_PAD_OE,
	input wire [KEY_W-1:0] KEY_PAD_PL,
	// Events and power state.
	input wire             PIN_IRQ,
	input wire             WAKE,
	input wire             STOP_ACTIVE
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);

	a_wait_once: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("Request not answered in the next cycle.");
	a_ack_single: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("Acknowledge longer than one cycle.");
	a_ack_asked: assert property (
		!AVS_WAITREQUEST |-> $past(AVS_READ) || $past(AVS_WRITE))
		else $error("Acknowledge without a request.");
	a_read_holds: assert property (
		AVS_WAITREQUEST && !AVS_READ && !AVS_WRITE |-> $stable(AVS_READDATA))
		else $error("Read data moved between requests.");
	a_pull_drive: assert property ((KEY_PAD_OE & KEY_PAD_PL) == '0)
		else $error("Pull-low enabled on a driven pad.");
	a_irq_edge: assert property ($rose(SNS_PAD_I[2]) |-> ##[1:5] PIN_IRQ)
		else $error("Rising pin gave no interrupt.");
	a_irq_pulse: assert property (PIN_IRQ |=> !PIN_IRQ)
		else $error("Interrupt pulse too long.");
	a_wake_exit: assert property (
		WAKE |-> !STOP_ACTIVE && $past(STOP_ACTIVE))
		else $error("Wake pulse outside a stop exit.");
	a_stop_freeze: assert property (
		STOP_ACTIVE && $past(STOP_ACTIVE) |-> $stable(KEY_PAD_OE) &&
		$stable(KEY_PAD_O) && $stable(COL_PAD_O))
		else $error("Pad changed in stop mode.");
endmodule

// [bench/mpc_pin_ctrl_tb_top.sv]
// Self-checking bench for the four-port pin controller.
`timescale 1ns/1ps
module mpc_pin_ctrl_tb_top;
	logic        clk, resetn, rd, wr, cs_n, sck, mosi, ovf, seen;
	logic [5:0]  adr;
	logic [3:0]  be;
	logic [31:0] wd;
	logic [7:0]  a, di, da, eoe, epl, eo;
	logic [2:0]  c, resistance_to_frequency_unit;
	logic [6:0]  lcd;
	logic [21:0] pin_interrupt, ext_en;
	wire  [21:0] po, poe, ppl, pi;
	wire  [31:0] rdata;
	wire         wait_q, miso, sense, irq, wake, stop;
	int          miscompares, tests_run;
	logic [31:0] exp_q[$];

	mpc_pin_ctrl mpc_pin_ctrl_i (.CLK(clk), .RESETN(resetn),
		.AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
		.AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_q),
		.SER_PAD_I(pi[3:0]), .SER_PAD_O(po[3:0]),
		.SER_PAD_OE(poe[3:0]), .SER_PAD_PL(ppl[3:0]),
		.COL_PAD_I(pi[7:4]), .COL_PAD_O(po[7:4]),
		.COL_PAD_OE(poe[7:4]), .COL_PAD_PL(ppl[7:4]),
		.SNS_PAD_I(pi[13:8]), .SNS_PAD_O(po[13:8]),
		.SNS_PAD_OE(poe[13:8]), .SNS_PAD_PL(ppl[13:8]),
		.KEY_PAD_I(pi[21:14]), .KEY_PAD_O(po[21:14]),
		.KEY_PAD_OE(poe[21:14]), .KEY_PAD_PL(ppl[21:14]),
		.SPI_CS_N(cs_n), .SPI_SCK(sck), .SPI_MOSI(mosi), .SPI_MISO(miso),
		.LCD_COLUMN_DRIVE(lcd), .RFC_DRIVE(resistance_to_frequency_unit), .RFC_SENSE(sense),
		.BUZZ_OVF(ovf), .PIN_IRQ(irq), .WAKE(wake), .STOP_ACTIVE(stop));
	mpc_far_model mpc_far_model_i (.clk(clk), .pad_o(po), .pad_oe(poe),
		.pad_pl(ppl), .pin_interrupt(pin_interrupt), .ext_en(ext_en), .pad_i(pi));

	task automatic chk(input string n, input logic [31:0] e, g);
		tests_run++;
		if (g !== e) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask

	// The request stands until waitrequest is seen low, however long.
	task automatic bus(input logic r, input logic [5:0] ad,
		input logic [31:0] d);
		@(posedge clk);
		adr <= ad;
		rd <= r;
		wr <= ~r;
		wd <= d;
		do begin
			@(posedge clk);
		end while (wait_q !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
	endtask

	task automatic rdx(input logic [5:0] ad, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b1, ad, 32'h0000_0000);
	endtask

	task automatic complete_run;
		$display("tests_run %0d miscompares %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	always @(posedge clk) begin
		if (rd && wait_q === 1'b0) begin
			if (exp_q.size() == 0) begin
				miscompares++;
				$display("[ERR] readdata expected none seen %h", rdata);
			end else
				chk("readdata", exp_q.pop_front(), rdata);
		end
	end

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		wt(20000);
		miscompares++;
		complete_run;
	end

	initial begin
		void'($urandom(48));
		resetn = 1'b0;
		{rd, wr, cs_n, sck, mosi, ovf} = 6'h00;
		adr = 6'h00;
		wd = 32'h0000_0000;
		be = 4'hF;
		{lcd, resistance_to_frequency_unit} = 10'h000;
		pin_interrupt = 22'h00_0000;
		ext_en = 22'h3F_FF0F;
		wt(16);
		resetn <= 1'b1;
		pin_interrupt <= 22'($urandom());
		wt(3);
		chk("pad_oe", 32'h0000_0000, 32'(poe));
		chk("pad_pl", 32'h003F_FFFF, 32'(ppl));
		for (int i = 0; i <= 48; i += 4) rdx(6'(i), 32'h0000_0000);
		rdx(6'h34, 32'(pin_interrupt & ext_en));
		be <= 4'h0;
		bus(1'b0, 6'h24, 32'h0000_00FF);
		be <= 4'hF;
		rdx(6'h24, 32'h0000_0000);
		for (int k = 0; k < 12; k++) begin
			a = 8'($urandom());
			di = 8'($urandom());
			da = 8'($urandom());
			for (int j = 0; j < 8; j++) begin
				c = {a[j], di[j], da[j]};
				eoe[j] = (c == 3'h2 || c == 3'h3);
				epl[j] = (c == 3'h0);
				eo[j] = (c == 3'h3);
			end
			bus(1'b0, 6'h2C, 32'(a));
			bus(1'b0, 6'h28, 32'(di));
			bus(1'b0, 6'h24, 32'(da));
			wt(3);
			chk("key_oe", 32'(eoe), 32'(poe[21:14]));
			chk("key_pl", 32'(epl), 32'(ppl[21:14]));
			chk("key_o", 32'(eo), 32'(po[21:14] & poe[21:14]));
		end
		bus(1'b0, 6'h00, 32'h0000_000F);
		bus(1'b0, 6'h04, 32'h0000_000F);
		bus(1'b0, 6'h30, 32'h0000_0001);
		{cs_n, sck, mosi} <= 3'($urandom());
		wt(3);
		chk("spi_o", 32'({mosi, sck, cs_n}), 32'({po[3], po[1:0]}));
		chk("spi_oe", 32'h0000_000B, 32'(poe[3:0]));
		bus(1'b0, 6'h00, 32'h0000_0000);
		pin_interrupt[2] <= ~pin_interrupt[2];
		wt(4);
		chk("miso", 32'(pin_interrupt[2]), 32'(miso));
		bus(1'b0, 6'h30, 32'h0000_0000);
		wt(3);
		chk("ser_pad", 32'h0000_00FF, 32'({poe[3:0], po[3:0]}));
		bus(1'b0, 6'h14, 32'h0000_000F);
		bus(1'b0, 6'h10, 32'h0000_000F);
		bus(1'b0, 6'h0C, 32'h0000_0000);
		bus(1'b0, 6'h20, 32'h0000_0038);
		bus(1'b0, 6'h1C, 32'h0000_0038);
		bus(1'b0, 6'h18, 32'h0000_0007);
		lcd <= 7'($urandom());
		resistance_to_frequency_unit <= 3'($urandom());
		pin_interrupt[10] <= 1'b0;
		wt(4);
		chk("col_o", 32'(lcd[3:0]), 32'(po[7:4]));
		chk("col_oe", 32'h0000_000F, 32'(poe[7:4]));
		chk("sns_col", 32'(lcd[6:4]), 32'(po[13:11]));
		bus(1'b0, 6'h30, 32'h0000_0002);
		wt(3);
		chk("rfc_o", 32'(resistance_to_frequency_unit), 32'(po[13:11]));
		chk("rfc_in", 32'h0000_0000, 32'({poe[10], ppl[10]}));
		pin_interrupt[10] <= 1'b1;
		seen = 1'b0;
		repeat (6) begin
			@(posedge clk);
			seen = seen | irq;
		end
		chk("irq", 32'h0000_0001, 32'(seen));
		chk("sense", 32'h0000_0001, 32'(sense));
		bus(1'b0, 6'h30, 32'h0000_000E);
		wt(3);
		for (int k = 0; k < 4; k++) begin
			chk("buzz", {30'h0, ~k[0], k[0]}, 32'(po[9:8]));
			chk("buzz_oe", 32'h0000_0003, 32'(poe[9:8]));
			ovf <= 1'b1;
			wt(1);
			ovf <= 1'b0;
			wt(3);
		end
		bus(1'b0, 6'h30, 32'h0000_0000);
		wt(3);
		chk("buzz_off", 32'h0000_0000, 32'(poe[9:8]));
		bus(1'b0, 6'h24, 32'h0000_00FF);
		bus(1'b0, 6'h28, 32'h0000_0000);
		bus(1'b0, 6'h2C, 32'h0000_0000);
		bus(1'b0, 6'h30, 32'h0000_0030);
		wt(4);
		chk("stop", 32'h0000_0001, 32'(stop));
		lcd <= ~lcd;
		wt(2);
		chk("col_kept", {28'h000_0000, ~lcd[3:0]}, 32'(po[7:4]));
		pin_interrupt[15] <= ~pin_interrupt[15];
		seen = 1'b0;
		repeat (8) begin
			@(posedge clk);
			seen = seen | wake;
		end
		chk("wake", 32'h0000_0001, 32'({stop, seen}));
		chk("ser_kept", 32'h0000_00FF, 32'({poe[3:0], po[3:0]}));
		rdx(6'h38, 32'h0000_0002);
		bus(1'b0, 6'h30, 32'h0000_0020);
		wt(4);
		pin_interrupt[14] <= ~pin_interrupt[14];
		wt(8);
		chk("no_wake", 32'h0000_0001, 32'(stop));
		complete_run;
	end
endmodule

bind mpc_pin_ctrl mpc_pin_ctrl_sva #(.COL_W(COL_W), .SNS_W(SNS_W),
	.KEY_W(KEY_W)) mpc_pin_ctrl_sva_i (.CLK(CLK), .RESETN(RESETN),
	.AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
	.AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
	.COL_PAD_O(COL_PAD_O), .SNS_PAD_I(SNS_PAD_I), .KEY_PAD_O(KEY_PAD_O),
	.KEY_PAD_OE(KEY_PAD_OE), .KEY_PAD_PL(KEY_PAD_PL), .PIN_IRQ(PIN_IRQ),
	.WAKE(WAKE), .STOP_ACTIVE(STOP_ACTIVE));
